// *** verilog/rcp_pin_logic.sv ***
`timescale 1ns/1ns
`default_nettype none
module rcp_pin_logic
  import rcp_pkg::*;
#(
  parameter int TICK_CYCLES = RCP_TICK_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic irq,
  // control lines
  input wire logic [7:0] control_lines_in,
  output logic [7:0] control_lines_out,
  output logic [7:0] control_lines_oe,
  // straps and mode pins
  input wire logic dir_low_group,
  input wire logic dir_high_group,
  input wire logic power_down_n,
  input wire logic latch_sel,
  input wire logic ack_enable,
  input wire logic ext_reset_n,
  input wire logic pair_button,
  // serial command pins
  input wire logic cmd_data_in,
  output logic cmd_data_out,
  // indicator and amplifier pins
  output logic rx_amp_enable,
  output logic tx_amp_enable,
  output logic activity_indicator,
  output logic ack_indication
);
  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("rcp_pin_logic: TICK_CYCLES below 2");
  end
  localparam int DIV_W = $clog2(TICK_CYCLES);
  typedef struct packed {
    logic [DIV_W-1:0] div_cnt;
    logic tick;
    logic [1:0] strap_cnt;
    logic strap_done;
    logic [1:0] dir_cap;
    logic [7:0] oe;
    logic [7:0] out;
    logic [7:0] rx_prev;
    logic [7:0] in_prev;
    logic [RCP_MS_W-1:0] hold_cnt;
    logic [RCP_MS_W-1:0] ack_cnt;
    logic ack_ind;
    logic [1:0] act_state;
    logic [RCP_MS_W-1:0] act_cnt;
    logic act_ind;
    logic pb_prev;
    logic [2:0] press_cnt;
    logic [RCP_MS_W-1:0] gap_cnt;
    logic rx_act;
    logic tx_act;
    logic rx_amp;
    logic tx_amp;
    logic cmd_out;
    logic [RCP_IRQ_W-1:0] ist;
    logic [RCP_IRQ_W-1:0] imsk;
    logic irq;
    logic wr_pend;
    logic rd_pend;
    logic hit;
    logic [7:0] addr;
    logic [31:0] rdata;
    logic ready;
  } rcp_st_t;
  rcp_st_t q;
  rcp_st_t d;

  // ****************************************
  // input synchronisers
  // ****************************************
  logic [14:0] pins_s;
  logic pb_s;
  logic [7:0] lines_s;
  logic dlo_s, dhi_s, pd_s, latch_s, acken_s, rstn_s, cmdin_s;
  // every strap and pin passes three flip-flops
  rcp_sync #(.WIDTH(15), .DEB_TICKS(0)) u_sync_pins (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .tick(q.tick),
    .din({cmd_data_in, ext_reset_n, ack_enable, latch_sel, power_down_n,
          dir_high_group, dir_low_group, control_lines_in}),
    .dout(pins_s)
  );
  // pair button also debounced on ms ticks
  rcp_sync #(.WIDTH(1), .DEB_TICKS(RCP_DEB_MS)) u_sync_pb (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .tick(q.tick),
    .din(pair_button),
    .dout(pb_s)
  );
  // split the synchronised pin word back into its signals
  assign {cmdin_s, rstn_s, acken_s, latch_s, pd_s, dhi_s, dlo_s, lines_s} = pins_s;
  // activity pulse width per operating state
  function automatic logic [RCP_MS_W-1:0] act_width(input logic [1:0] st);
    case (st)
      2'h0: act_width = RCP_ACT_MS0;
      2'h1: act_width = RCP_ACT_MS1;
      2'h2: act_width = RCP_ACT_MS2;
      default: act_width = RCP_ACT_MS3;
    endcase
  endfunction

  // ****************************************
  // bus write strobes and block events
  // ****************************************
  logic acc, wr_ctrl, wr_rxl, wr_ist, wr_msk, live, rx_evt, ack_evt, pb_rise;
  logic [7:0] rx_bits;
  logic [7:0] in_rise;
  assign acc = hsel & htrans[1] & hready;
  assign wr_ctrl = q.wr_pend & q.hit & (q.addr == RCP_CTRL_OFS);
  assign wr_rxl = q.wr_pend & q.hit & (q.addr == RCP_RXL_OFS);
  assign wr_ist = q.wr_pend & q.hit & (q.addr == RCP_IST_OFS);
  assign wr_msk = q.wr_pend & q.hit & (q.addr == RCP_IMSK_OFS);
  assign live = pd_s & q.strap_done;
  assign rx_evt = wr_rxl & live;
  assign rx_bits = hwdata[7:0] & q.oe;
  assign ack_evt = wr_ctrl & hwdata[RCP_CTRL_ACK] & live;
  assign pb_rise = pb_s & ~q.pb_prev & live;
  assign in_rise = lines_s & ~q.in_prev & ~q.oe;

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    d = q;
    // ms tick divider
    if (q.div_cnt == DIV_W'(TICK_CYCLES - 1)) begin
      d.div_cnt = '0;
      d.tick = 1'b1;
    end else begin
      d.div_cnt = q.div_cnt + DIV_W'(1);
      d.tick = 1'b0;
    end
    // strap capture a few cycles after reset
    if (!q.strap_done) begin
      d.strap_cnt = q.strap_cnt + 2'h1;
      if (q.strap_cnt == RCP_STRAP_WAIT) begin
        d.strap_done = 1'b1;
        d.dir_cap = {dhi_s, dlo_s};
        d.oe = {{4{~dhi_s}}, {4{~dlo_s}}};
      end
    end
    // control line outputs
    if (rx_evt) begin
      d.rx_prev = rx_bits;
      if (latch_s) begin
        d.out = (q.out ^ (rx_bits & ~q.rx_prev)) & q.oe;
      end else begin
        d.out = rx_bits;
        d.hold_cnt = RCP_MOMENT_MS;
      end
    end else if (q.tick && q.hold_cnt != '0) begin
      d.hold_cnt = q.hold_cnt - 11'h001;
      if (q.hold_cnt == 11'h001 && !latch_s) begin
        d.out = 8'h00;
      end
    end
    d.in_prev = lines_s;
    // pair button presses and factory sequence
    d.pb_prev = pb_s;
    if (pb_rise) begin
      d.gap_cnt = RCP_GAP_MS;
      if (q.press_cnt + 3'h1 == RCP_FACT_PRESSES) begin
        d.press_cnt = 3'h0;
      end else begin
        d.press_cnt = q.press_cnt + 3'h1;
      end
    end else if (q.tick && q.gap_cnt != '0) begin
      d.gap_cnt = q.gap_cnt - 11'h001;
      if (q.gap_cnt == 11'h001) begin
        d.press_cnt = 3'h0;
      end
    end
    // acknowledgement indication hold
    if (ack_evt) begin
      d.ack_cnt = RCP_ACK_MS;
    end else if (q.tick && q.ack_cnt != '0) begin
      d.ack_cnt = q.ack_cnt - 11'h001;
    end
    // activity indicator: period on ticks, width by state
    if (q.tick) begin
      if (q.act_cnt == RCP_ACT_PERIOD_MS - 11'h001) begin
        d.act_cnt = '0;
      end else begin
        d.act_cnt = q.act_cnt + 11'h001;
      end
    end
    d.act_ind = live & (q.act_cnt < act_width(q.act_state));
    // control register write
    if (wr_ctrl) begin
      d.rx_act = hwdata[RCP_CTRL_RX];
      d.tx_act = hwdata[RCP_CTRL_TX];
      d.cmd_out = hwdata[RCP_CTRL_CMD];
      d.act_state = hwdata[RCP_CTRL_ACT+1:RCP_CTRL_ACT];
    end
    if (wr_msk) begin
      d.imsk = hwdata[RCP_IRQ_W-1:0];
    end
    // sticky events: write-one clears, a new event wins
    d.ist = q.ist & ~(wr_ist ? hwdata[RCP_IRQ_W-1:0] : 4'h0);
    if (live && in_rise != 8'h00) begin
      d.ist[RCP_IRQ_IN] = 1'b1;
    end
    if (pb_rise) begin
      d.ist[RCP_IRQ_JOIN] = 1'b1;
    end
    if (pb_rise && q.press_cnt + 3'h1 == RCP_FACT_PRESSES) begin
      d.ist[RCP_IRQ_FACT] = 1'b1;
    end
    if (rx_evt && acken_s) begin
      d.ist[RCP_IRQ_ACKREQ] = 1'b1;
    end
    // power-down: no outputs, no amplifiers
    if (!pd_s) begin
      d.out = 8'h00;
      d.hold_cnt = '0;
      d.ack_cnt = '0;
    end
    d.ack_ind = (d.ack_cnt != '0);
    d.rx_amp = d.rx_act & pd_s;
    d.tx_amp = d.tx_act & pd_s;
    d.irq = |(d.ist & d.imsk);
    // ahb-lite: writes zero-wait, reads one wait state
    d.wr_pend = acc & hwrite;
    if (acc) begin
      d.addr = haddr[7:0];
      d.hit = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);
    end
    d.rd_pend = acc & ~hwrite;
    d.ready = ~d.rd_pend;
    if (q.rd_pend) begin
      d.rdata = 32'h00000000;
      if (q.hit) begin
        case (q.addr)
          RCP_CTRL_OFS: d.rdata = {26'h0, q.act_state, 1'b0, q.cmd_out, q.tx_act, q.rx_act};
          RCP_RXL_OFS: d.rdata = {24'h0, q.rx_prev};
          RCP_PIN_OFS: d.rdata = {16'h0, q.strap_done, cmdin_s, pb_s, acken_s, latch_s, pd_s, q.dir_cap,
                                 lines_s};
          RCP_IST_OFS: d.rdata = {28'h0, q.ist};
          RCP_IMSK_OFS: d.rdata = {28'h0, q.imsk};
          RCP_OUT_OFS: d.rdata = {16'h0, q.oe, q.out};
          default: d.rdata = 32'h00000000;
        endcase
      end
    end
    // reset pin clears the block and resamples straps
    if (!rstn_s) begin
      d = '0;
      d.ready = 1'b1;
      d.cmd_out = 1'b1;
    end
  end

  // ****************************************
  // state register and outputs
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      q <= '0;
      q.ready <= 1'b1;
      q.cmd_out <= 1'b1;
    end else begin
      q <= d;
    end
  end
  assign hreadyout = q.ready;
  assign hrdata = q.rdata;
  assign hresp = 1'b0;
  assign irq = q.irq;
  assign control_lines_out = q.out; // out is only ever loaded through the oe mask
  assign control_lines_oe = q.oe;
  assign cmd_data_out = q.cmd_out;
  assign rx_amp_enable = q.rx_amp;
  assign tx_amp_enable = q.tx_amp;
  assign activity_indicator = q.act_ind;
  assign ack_indication = q.ack_ind;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  property p_dir_low;
    $rose(q.strap_done) |-> control_lines_oe[3:0] == {4{~$past(dlo_s)}} ##1 $stable(control_lines_oe[3:0]);
  endproperty
  a_dir_low: assert property (p_dir_low) else $error("low group direction wrong");
  property p_dir_high;
    q.strap_done && $stable(q.strap_done) |-> control_lines_oe[7:4] == {4{~q.dir_cap[1]}};
  endproperty
  a_dir_high: assert property (p_dir_high) else $error("high group direction wrong");
  property p_no_drive_input;
    (control_lines_out & ~control_lines_oe) == 8'h00;
  endproperty
  a_no_drive_input: assert property (p_no_drive_input) else $error("input line driven");
  property p_powerdown;
    !pd_s && rstn_s |=> control_lines_out == 8'h00 && !rx_amp_enable && !tx_amp_enable && !ack_indication;
  endproperty
  a_powerdown: assert property (p_powerdown) else $error("active during power-down");
  property p_pin_reset;
    !rstn_s |=> control_lines_oe == 8'h00 && irq == 1'b0 && !q.strap_done;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("reset pin ignored");
  property p_toggle;
    rx_evt && latch_s && rstn_s && rx_bits[0] && !q.rx_prev[0] |=> control_lines_out[0] != $past(q.out[0]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("latched output did not toggle");
  property p_momentary;
    rx_evt && !latch_s && rstn_s |=> control_lines_out == $past(rx_bits);
  endproperty
  a_momentary: assert property (p_momentary) else $error("momentary output wrong");
  property p_ack_request;
    rx_evt && acken_s && rstn_s |=> q.ist[RCP_IRQ_ACKREQ] && (irq || !q.imsk[RCP_IRQ_ACKREQ]);
  endproperty
  a_ack_request: assert property (p_ack_request) else $error("ack request not raised");
  property p_ack_ind;
    ack_evt && rstn_s |=> ack_indication ##1 (ack_indication || $past(!pd_s || !rstn_s));
  endproperty
  a_ack_ind: assert property (p_ack_ind) else $error("ack indication missing");
  property p_amps;
    rstn_s && pd_s && q.rx_act && q.tx_act && !wr_ctrl |=> rx_amp_enable && tx_amp_enable;
  endproperty
  a_amps: assert property (p_amps) else $error("amplifier enable low");
  property p_join;
    pb_rise && rstn_s |=> q.ist[RCP_IRQ_JOIN];
  endproperty
  a_join: assert property (p_join) else $error("join event lost");
endmodule
`default_nettype wire

// *** verilog/rcp_pkg.sv ***
`default_nettype none
package rcp_pkg;
  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] RCP_CTRL_OFS = 8'h00;
  localparam logic [7:0] RCP_RXL_OFS = 8'h04;
  localparam logic [7:0] RCP_PIN_OFS = 8'h08;
  localparam logic [7:0] RCP_IST_OFS = 8'h0C;
  localparam logic [7:0] RCP_IMSK_OFS = 8'h10;
  localparam logic [7:0] RCP_OUT_OFS = 8'h14;

  // ****************************************
  // field positions
  // ****************************************
  localparam int RCP_CTRL_RX = 0;
  localparam int RCP_CTRL_TX = 1;
  localparam int RCP_CTRL_CMD = 2;
  localparam int RCP_CTRL_ACK = 3;
  localparam int RCP_CTRL_ACT = 4;
  localparam int RCP_IRQ_IN = 0;
  localparam int RCP_IRQ_JOIN = 1;
  localparam int RCP_IRQ_FACT = 2;
  localparam int RCP_IRQ_ACKREQ = 3;
  localparam int RCP_IRQ_W = 4;

  // ****************************************
  // timing
  // ****************************************
  localparam int RCP_CLK_MHZ = 125;
  localparam int RCP_TICK_US = 1000;
  localparam int RCP_TICK_CYC = RCP_TICK_US * RCP_CLK_MHZ;
  localparam int RCP_MS_W = 11;
  localparam logic [10:0] RCP_MOMENT_MS = 11'h2F8;
  localparam logic [10:0] RCP_ACK_MS = 11'h014;
  localparam int RCP_DEB_MS = 10;
  localparam logic [10:0] RCP_GAP_MS = 11'h3E8;
  localparam logic [2:0] RCP_FACT_PRESSES = 3'h4;
  localparam logic [10:0] RCP_ACT_PERIOD_MS = 11'h3E8;
  localparam logic [10:0] RCP_ACT_MS0 = 11'h000;
  localparam logic [10:0] RCP_ACT_MS1 = 11'h032;
  localparam logic [10:0] RCP_ACT_MS2 = 11'h0C8;
  localparam logic [10:0] RCP_ACT_MS3 = 11'h1F4;
  localparam logic [1:0] RCP_STRAP_WAIT = 2'h3;
endpackage
`default_nettype wire

// *** verilog/rcp_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
module rcp_sync
  import rcp_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter int DEB_TICKS = 0
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic tick,
  // raw pins and clean result
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  // refuse widths and filter lengths the 8-bit counter cannot serve
  if (WIDTH < 1 || DEB_TICKS < 0 || DEB_TICKS > 255) begin : g_bad_param
    $error("rcp_sync: bad parameters");
  end

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] stable;
    logic [7:0] cnt;
  } rcp_sync_st_t;

  rcp_sync_st_t q;
  rcp_sync_st_t d;

  // two-flop synchroniser, then optional stability filter on ms ticks
  always_comb begin
    d = q;
    d.s1 = din;
    d.s2 = q.s1;
    if (DEB_TICKS == 0) begin
      d.stable = q.s2;
    end else if (q.s2 == q.stable) begin
      d.cnt = 8'h00;
    end else if (tick) begin
      if (q.cnt == 8'(DEB_TICKS - 1)) begin
        d.stable = q.s2;
        d.cnt = 8'h00;
      end else begin
        d.cnt = q.cnt + 8'h01;
      end
    end
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign dout = q.stable;
endmodule
`default_nettype wire

// *** testbench/rcp_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module rcp_host_model (
  // design side of the lines
  input wire logic [7:0] control_lines_out,
  input wire logic [7:0] control_lines_oe,
  // contacts closed by the bench
  input wire logic [7:0] buttons,
  // resolved pin levels
  output logic [7:0] control_lines_in
);
  // ****************************************
  // line resolution
  // ****************************************
  // driven lines show the design level, released lines the contact
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      control_lines_in[i] = control_lines_oe[i] ? control_lines_out[i] : buttons[i];
    end
  end
endmodule
`default_nettype wire

// *** testbench/remote_control_pin_logic_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module remote_control_pin_logic_tb;
  import rcp_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  localparam int TK = 4;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, irq, cmd_data_out, rx_amp_enable, tx_amp_enable, activity_indicator, ack_indication;
  logic [31:0] hrdata;
  logic [7:0] control_lines_in, control_lines_out, control_lines_oe;
  logic dir_low_group = 1'b0;
  logic dir_high_group = 1'b1;
  logic power_down_n = 1'b1;
  logic latch_sel = 1'b1;
  logic ack_enable = 1'b0;
  logic ext_reset_n = 1'b1;
  logic pair_button = 1'b0;
  logic cmd_data_in = 1'b1;
  logic [7:0] buttons = 8'h00;
  logic rdy = 1'b1;
  logic [31:0] rdq = 32'h0;
  logic [7:0] cur, prev, bits;
  int fails = 0;
  int n_tests = 0;
  int seed = 32'h4f2d54b9;
  int cnt;
  int widths [4] = '{0, 50, 200, 500};

  // clock, and bus answer as seen at the coming edge
  always #4 sys_clk = ~sys_clk;
  always @(negedge sys_clk) begin
    rdy <= hreadyout;
    rdq <= hrdata;
  end

  rcp_pin_logic #(.TICK_CYCLES(TK)) i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .irq(irq), .control_lines_in(control_lines_in),
    .control_lines_out(control_lines_out), .control_lines_oe(control_lines_oe), .dir_low_group(dir_low_group),
    .dir_high_group(dir_high_group), .power_down_n(power_down_n), .latch_sel(latch_sel), .ack_enable(ack_enable),
    .ext_reset_n(ext_reset_n), .pair_button(pair_button), .cmd_data_in(cmd_data_in),
    .cmd_data_out(cmd_data_out), .rx_amp_enable(rx_amp_enable), .tx_amp_enable(tx_amp_enable),
    .activity_indicator(activity_indicator), .ack_indication(ack_indication));

  rcp_host_model i_host (.control_lines_out(control_lines_out), .control_lines_oe(control_lines_oe),
    .buttons(buttons), .control_lines_in(control_lines_in));

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // one single ahb-lite transfer, held until hready is seen high
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge sys_clk); while (rdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk); while (rdy !== 1'b1);
    rd = rdq;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(x, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic press;
    @(posedge sys_clk) pair_button <= 1'b1;
    cyc(80);
    @(posedge sys_clk) pair_button <= 1'b0;
    cyc(80);
  endtask

  // expected line state after one received activation in latched mode
  function automatic logic [7:0] latch_exp(logic [7:0] c, logic [7:0] p, logic [7:0] b, logic [7:0] oe);
    return (c ^ (b & ~p)) & oe;
  endfunction

  // expected pin status word for the given line levels
  function automatic logic [31:0] pin_exp(logic [7:0] lines);
    return {16'h0, 1'b1, cmd_data_in, pair_button, ack_enable, latch_sel, power_down_n, dir_high_group,
      dir_low_group, lines};
  endfunction

  task final_report;
    if (fails == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ****************************************
  // watchdog
  // ****************************************
  initial begin
    #(60000 * 8);
    fails++;
    final_report();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    cyc(12);
    chk({29'h0, hreadyout, cmd_data_out, irq}, 32'h6);
    chk({24'h0, control_lines_oe}, 32'h0F);
    rd_chk(RCP_CTRL_OFS, 32'h4);
    rd_chk(RCP_IMSK_OFS, 32'h0);
    rd_chk(RCP_OUT_OFS, 32'h0F00);
    wr(8'h18, 32'hFFFF_FFFF);
    rd_chk(8'h18, 32'h0);
    @(posedge sys_clk) cmd_data_in <= 1'b0;
    cyc(6);
    rd_chk(RCP_PIN_OFS, pin_exp(8'h00));
    // latched toggling, repeated bit first, then random patterns
    cur = 8'h00;
    prev = 8'h00;
    for (int i = 0; i < 8; i++) begin
      bits = (i < 2) ? 8'h01 : 8'($random(seed));
      wr(RCP_RXL_OFS, {24'h0, bits});
      cyc(1);
      cur = latch_exp(cur, prev, bits, 8'h0F);
      prev = bits;
      chk({24'h0, control_lines_out}, {24'h0, cur});
    end
    rd_chk(RCP_OUT_OFS, {16'h0, 8'h0F, cur});
    rd_chk(RCP_IST_OFS, 32'h0);
    // momentary output and its hold time
    @(posedge sys_clk) latch_sel <= 1'b0;
    cyc(6);
    wr(RCP_RXL_OFS, 32'h35);
    cyc(1);
    chk({24'h0, control_lines_out}, 32'h05);
    cyc(2900);
    chk({24'h0, control_lines_out}, 32'h05);
    cyc(300);
    chk({24'h0, control_lines_out}, 32'h00);
    // acknowledgement request and interrupt mask and clear
    @(posedge sys_clk) ack_enable <= 1'b1;
    cyc(6);
    wr(RCP_RXL_OFS, 32'h01);
    rd_chk(RCP_IST_OFS, 32'h8);
    chk({31'h0, irq}, 32'h0);
    wr(RCP_IMSK_OFS, 32'h8);
    cyc(2);
    chk({31'h0, irq}, 32'h1);
    wr(RCP_IST_OFS, 32'h8);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    @(posedge sys_clk) ack_enable <= 1'b0;
    // input line closure on the high group
    @(posedge sys_clk) buttons <= 8'h90;
    cyc(10);
    rd_chk(RCP_IST_OFS, 32'h1);
    rd_chk(RCP_PIN_OFS, pin_exp(8'h91));
    wr(RCP_IST_OFS, 32'hF);
    // a short bounce on the pair button must be filtered out
    @(posedge sys_clk) pair_button <= 1'b1;
    cyc(12);
    @(posedge sys_clk) pair_button <= 1'b0;
    cyc(60);
    rd_chk(RCP_IST_OFS, 32'h0);
    // join, then factory sequence of four presses
    press();
    rd_chk(RCP_IST_OFS, 32'h2);
    wr(RCP_IST_OFS, 32'hF);
    repeat (3) press();
    rd_chk(RCP_IST_OFS, 32'h6);
    // amplifier enables and command output for every setting
    for (int v = 0; v < 8; v++) begin
      wr(RCP_CTRL_OFS, v);
      cyc(1);
      chk({29'h0, cmd_data_out, tx_amp_enable, rx_amp_enable}, v);
    end
    // power down stops amplifiers and ignores activations
    @(posedge sys_clk) power_down_n <= 1'b0;
    cyc(6);
    wr(RCP_RXL_OFS, 32'h0F);
    cyc(1);
    chk({22'h0, rx_amp_enable, tx_amp_enable, control_lines_out}, 32'h0);
    @(posedge sys_clk) power_down_n <= 1'b1;
    cyc(6);
    chk({30'h0, rx_amp_enable, tx_amp_enable}, 32'h3);
    // acknowledgement indication
    wr(RCP_CTRL_OFS, 32'h8);
    cyc(2);
    chk({31'h0, ack_indication}, 32'h1);
    cyc(100);
    chk({31'h0, ack_indication}, 32'h0);
    // activity pulse width for each state over one full period
    for (int s = 0; s < 4; s++) begin
      wr(RCP_CTRL_OFS, s << 4);
      cnt = 0;
      repeat (4000) begin
        cyc(1);
        if (activity_indicator === 1'b1) cnt++;
      end
      chk({31'h0, (cnt >= widths[s] * TK - 8) && (cnt <= widths[s] * TK + 8)}, 32'h1);
    end
    // pin reset clears state and takes the new strap levels
    wr(RCP_CTRL_OFS, 32'h3);
    wr(RCP_RXL_OFS, 32'h0F);
    @(posedge sys_clk) ext_reset_n <= 1'b0;
    cyc(10);
    @(posedge sys_clk) begin
      ext_reset_n <= 1'b1;
      dir_low_group <= 1'b1;
      dir_high_group <= 1'b0;
    end
    cyc(20);
    chk({23'h0, rx_amp_enable, control_lines_out}, 32'h0);
    chk({24'h0, control_lines_oe}, 32'hF0);
    rd_chk(RCP_CTRL_OFS, 32'h4);
    final_report();
  end
endmodule
`default_nettype wire
